// >>> rtl/bus_arb_pkg.sv
// Shared constants and types for the address bus arbitration master.
package bus_arb_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    // Bus clock period and the least time that busy is driven negated.
    localparam int CLK_PERIOD_NS = 40;
    localparam int BUSY_NEG_MIN_NS = 20;
    // Least time rounds up, and never below one cycle.
    localparam int BUSY_NEG_RAW = (BUSY_NEG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_NEG_CYCLES = (BUSY_NEG_RAW < 1) ? 1 : BUSY_NEG_RAW;
    localparam logic [3:0] NEG_CNT_LAST = 4'(BUSY_NEG_CYCLES - 1);

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic PIN_NEGATED = 1'b1;
    localparam logic PIN_RELEASED = 1'b0;

    // ==========================================================
    // Master state machine
    // ==========================================================
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_TENURE = 4'h4,
        ST_RELEASE = 4'h8
    } arb_state_t;

    typedef struct packed {
        arb_state_t st;
        logic [3:0] neg_cnt;
        logic br_n;
        logic br_oe;
        logic abb_n;
        logic abb_oe;
        logic ts_n;
        logic ts_oe;
        logic attr_oe;
        logic dbr;
        logic started;
        logic done;
    } master_t;

    typedef struct packed {
        logic open;
        logic address_acknowledge_prev;
    } tracker_t;

    typedef struct packed {
        logic qual_prev;
    } qualifier_t;

endpackage : bus_arb_pkg

// >>> rtl/arb_view_if.sv
// Bus occupancy and grant view shared between the arbitration modules.
interface arb_view_if;
    logic bus_busy;
    logic tenure_open;
    logic retry_hit;
    logic grant_ok;

    modport tracker (output bus_busy, output tenure_open, output retry_hit);
    modport qualifier (input bus_busy, input tenure_open, input retry_hit, output grant_ok);
    modport master (input bus_busy, input tenure_open, input retry_hit, input grant_ok);
endinterface : arb_view_if

// >>> rtl/bus_occupancy_tracker.sv
// Tracks address bus occupancy from snooped transfer start and acknowledge.
module bus_occupancy_tracker
    import bus_arb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic transfer_start_in_n,
    input wire logic address_bus_busy_in_n,
    input wire logic address_acknowledge_n,
    input wire logic address_retry_n,
    arb_view_if.tracker av
);

    tracker_t r;
    tracker_t next_r;

    // ==========================================================
    // Occupancy state
    // ==========================================================
    // A start opens the tenure window, the acknowledge closes it.
    always_comb
    begin
        next_r = r;
        next_r.address_acknowledge_prev = ~address_acknowledge_n;
        if (!transfer_start_in_n)
        begin
            next_r.open = 1'b1;
        end
        else if (!address_acknowledge_n)
        begin
            next_r.open = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // The start cycle itself already counts as occupied.
    assign av.tenure_open = r.open | ~transfer_start_in_n;
    assign av.bus_busy = ~address_bus_busy_in_n | av.tenure_open;
    // Retry only counts in the cycle after an acknowledge.
    assign av.retry_hit = r.address_acknowledge_prev & ~address_retry_n;

    a_track_open_start: assert property (@(posedge clk) disable iff (!resetn)
        !transfer_start_in_n |=> av.tenure_open)
        else $error("Tenure window not opened by transfer start.");

endmodule : bus_occupancy_tracker

// >>> rtl/grant_qualifier.sv
// Decides whether a grant is qualified this cycle or carried from the last.
module grant_qualifier
    import bus_arb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic bus_grant_in_n,
    arb_view_if.qualifier av
);

    qualifier_t r;
    qualifier_t next_r;
    logic bus_free;
    logic qualified;

    // ==========================================================
    // Qualification
    // ==========================================================
    // Free means no busy, no open tenure and no retry after acknowledge.
    always_comb
    begin
        bus_free = ~av.bus_busy & ~av.tenure_open & ~av.retry_hit;
        qualified = ~bus_grant_in_n & bus_free;
        next_r.qual_prev = qualified;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // A grant negated now still counts if it qualified last cycle and the bus is still free.
    assign av.grant_ok = qualified | (r.qual_prev & bus_free);

    a_qual_needs_free: assert property (@(posedge clk) disable iff (!resetn)
        av.retry_hit |-> !av.grant_ok)
        else $error("Grant accepted during a qualified retry.");

endmodule : grant_qualifier

// >>> rtl/address_bus_master_arbitration.sv
// Address bus master: request, grant acceptance, busy and transfer start.
module address_bus_master_arbitration
    import bus_arb_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic checkstop,
    input wire logic txn_pending,
    input wire logic txn_cancel,
    input wire logic txn_has_data,
    input wire logic zero_block_pulse,
    input wire logic touch_hit_pulse,
    input wire logic own_retry_copyback,
    input wire logic bus_grant_in_n,
    input wire logic address_bus_busy_in_n,
    input wire logic transfer_start_in_n,
    input wire logic address_acknowledge_n,
    input wire logic address_retry_n,
    output logic bus_request_out_n,
    output logic bus_request_out_oe,
    output logic address_bus_busy_out_n,
    output logic address_bus_busy_oe,
    output logic transfer_start_out_n,
    output logic transfer_start_oe,
    output logic attribute_drive_en,
    output logic data_bus_request,
    output logic txn_started,
    output logic tenure_done
);

    arb_view_if av ();

    master_t r;
    master_t next_r;
    logic pending;
    logic take;
    logic parked_idle;
    logic retry_block;
    logic want_br;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Occupancy is tracked from snooped pins, not only from busy.
    bus_occupancy_tracker u_tracker (
        .clk(clk),
        .resetn(resetn),
        .transfer_start_in_n(transfer_start_in_n),
        .address_bus_busy_in_n(address_bus_busy_in_n),
        .address_acknowledge_n(address_acknowledge_n),
        .address_retry_n(address_retry_n),
        .av(av.tracker)
    );

    grant_qualifier u_qual (
        .clk(clk),
        .resetn(resetn),
        .bus_grant_in_n(bus_grant_in_n),
        .av(av.qualifier)
    );

    // ==========================================================
    // Request conditions
    // ==========================================================
    // A cancel in the grant cycle wins over the grant, so no tenure starts.
    always_comb
    begin
        pending = txn_pending & ~txn_cancel;
        take = pending & av.grant_ok;
        parked_idle = ~bus_grant_in_n & ~av.bus_busy;
        retry_block = av.retry_hit & ~own_retry_copyback;
        want_br = (pending & ~parked_idle & ~retry_block)
            | zero_block_pulse | touch_hit_pulse;
    end

    // ==========================================================
    // Master state machine
    // ==========================================================
    // All pin values are computed here one cycle ahead so that every
    // output leaves a flip-flop; the cost is that request follows its
    // causes by one cycle, which the bus timing already expects.
    always_comb
    begin
        next_r = r;
        next_r.started = 1'b0;
        next_r.dbr = 1'b0;
        next_r.done = 1'b0;
        next_r.br_n = ~want_br;
        next_r.br_oe = ~checkstop;
        unique case (r.st)
            ST_IDLE:
            begin
                if (take)
                begin
                    next_r.st = ST_START;
                end
            end
            ST_START, ST_TENURE:
            begin
                // Grant is not looked at while the tenure runs.
                next_r.ts_n = PIN_NEGATED;
                next_r.st = ST_TENURE;
                if (!address_acknowledge_n)
                begin
                    next_r.st = ST_RELEASE;
                    next_r.abb_n = PIN_NEGATED;
                    next_r.ts_oe = PIN_RELEASED;
                    next_r.attr_oe = 1'b0;
                    next_r.done = 1'b1;
                    next_r.neg_cnt = NEG_CNT_LAST;
                end
            end
            ST_RELEASE:
            begin
                if (r.neg_cnt != 4'h0)
                begin
                    next_r.neg_cnt = r.neg_cnt - 4'h1;
                end
                else if (take)
                begin
                    // Tenure completes: the next transaction may go.
                    next_r.st = ST_START;
                end
                else
                begin
                    next_r.st = ST_IDLE;
                    next_r.abb_oe = PIN_RELEASED;
                end
            end
            default:
            begin
                next_r.st = ST_IDLE;
            end
        endcase
        if (next_r.st == ST_START)
        begin
            // Start pulse with busy, attributes and request dropped.
            next_r.ts_n = 1'b0;
            next_r.ts_oe = 1'b1;
            next_r.abb_n = 1'b0;
            next_r.abb_oe = 1'b1;
            next_r.attr_oe = 1'b1;
            next_r.br_n = PIN_NEGATED;
            next_r.dbr = txn_has_data;
            next_r.started = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            r.st <= ST_IDLE;
            r.neg_cnt <= 4'h0;
            r.br_n <= PIN_NEGATED;
            r.br_oe <= PIN_RELEASED;
            r.abb_n <= PIN_NEGATED;
            r.abb_oe <= PIN_RELEASED;
            r.ts_n <= PIN_NEGATED;
            r.ts_oe <= PIN_RELEASED;
            r.attr_oe <= 1'b0;
            r.dbr <= 1'b0;
            r.started <= 1'b0;
            r.done <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign bus_request_out_n = r.br_n;
    assign bus_request_out_oe = r.br_oe;
    assign address_bus_busy_out_n = r.abb_n;
    assign address_bus_busy_oe = r.abb_oe;
    assign transfer_start_out_n = r.ts_n;
    assign transfer_start_oe = r.ts_oe;
    assign attribute_drive_en = r.attr_oe;
    assign data_bus_request = r.dbr;
    assign txn_started = r.started;
    assign tenure_done = r.done;

    // ==========================================================
    // Checks
    // ==========================================================
    a_ts_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
        (!transfer_start_out_n && transfer_start_oe) |=> transfer_start_out_n)
        else $error("Transfer start held longer than one cycle.");

    a_br_off_start: assert property (@(posedge clk) disable iff (!resetn)
        !transfer_start_out_n |-> bus_request_out_n)
        else $error("Request asserted in the start cycle.");

    a_br_float_stop: assert property (@(posedge clk) disable iff (!resetn)
        checkstop |=> !bus_request_out_oe)
        else $error("Request driven during checkstop.");

    a_abb_after_take: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == ST_IDLE && take) |=> (!address_bus_busy_out_n && address_bus_busy_oe
            && !transfer_start_out_n && attribute_drive_en))
        else $error("Busy or start missing after accepted grant.");

    a_abb_hold_tenure: assert property (@(posedge clk) disable iff (!resetn)
        (!address_bus_busy_out_n && address_acknowledge_n) |=> !address_bus_busy_out_n)
        else $error("Busy dropped before acknowledge.");

    a_abb_neg_release: assert property (@(posedge clk) disable iff (!resetn)
        (!address_acknowledge_n && !address_bus_busy_out_n)
            |=> (address_bus_busy_out_n && address_bus_busy_oe && tenure_done))
        else $error("Busy not driven negated after acknowledge.");

    a_ts_release: assert property (@(posedge clk) disable iff (!resetn)
        (!address_acknowledge_n && transfer_start_oe) |=> !transfer_start_oe)
        else $error("Transfer start not released after acknowledge.");

    a_retry_drops_br: assert property (@(posedge clk) disable iff (!resetn)
        (av.retry_hit && !own_retry_copyback && !zero_block_pulse && !touch_hit_pulse)
            |=> bus_request_out_n)
        else $error("Request kept after a qualified retry.");

    a_cancel_no_take: assert property (@(posedge clk) disable iff (!resetn)
        (txn_cancel && r.st == ST_IDLE) |=> transfer_start_out_n)
        else $error("Bus taken by a cancelled transaction.");

    a_parked_no_br: assert property (@(posedge clk) disable iff (!resetn)
        (parked_idle && !zero_block_pulse && !touch_hit_pulse) |=> bus_request_out_n)
        else $error("Request asserted while parked on an idle bus.");

    a_pulse_br: assert property (@(posedge clk) disable iff (!resetn)
        ((zero_block_pulse || touch_hit_pulse) && !take) |=> !bus_request_out_n)
        else $error("Request pulse missing for zero-block or touch hit.");

    a_data_request: assert property (@(posedge clk) disable iff (!resetn)
        txn_started |-> (data_bus_request == $past(txn_has_data)))
        else $error("Data bus request does not follow the transfer kind.");

    a_dbr_only_start: assert property (@(posedge clk) disable iff (!resetn)
        data_bus_request |-> txn_started)
        else $error("Data bus request outside a start cycle.");

    a_busy_with_start: assert property (@(posedge clk) disable iff (!resetn)
        txn_started |-> (!address_bus_busy_out_n && address_bus_busy_oe))
        else $error("Busy not asserted together with the start.");

    a_br_cancel_drop: assert property (@(posedge clk) disable iff (!resetn)
        (txn_cancel && !zero_block_pulse && !touch_hit_pulse) |=> bus_request_out_n)
        else $error("Request kept for a cancelled transaction.");

    a_br_when_pending: assert property (@(posedge clk) disable iff (!resetn)
        (txn_pending && !txn_cancel && bus_grant_in_n && !av.retry_hit && !take)
            |=> !bus_request_out_n)
        else $error("Request missing while a transaction waits.");

    // Grant-path checks: the first watches the snooped start, so none of ours
    // can start in the cycle right after a foreign start.
    a_start_blocks_take: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == ST_IDLE && !transfer_start_in_n) |=> transfer_start_out_n)
        else $error("Grant accepted in the cycle of a bus start.");

    a_tenure_no_regrant: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == ST_TENURE) |=> (r.st != ST_START))
        else $error("Grant evaluated again before the tenure completed.");

    a_parked_take: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == ST_IDLE && !bus_grant_in_n && txn_pending && !txn_cancel
            && !av.bus_busy && !av.retry_hit) |=> (txn_started && bus_request_out_n))
        else $error("Parked master did not take the idle bus.");

    a_carried_grant: assert property (@(posedge clk) disable iff (!resetn)
        (r.st == ST_IDLE && txn_pending && !txn_cancel && bus_grant_in_n && $past(resetn)
            && !$past(bus_grant_in_n) && !$past(av.bus_busy) && !$past(av.retry_hit)
            && !av.bus_busy && !av.retry_hit) |=> txn_started)
        else $error("Grant qualified last cycle was not used.");

    a_attr_with_start: assert property (@(posedge clk) disable iff (!resetn)
        !transfer_start_out_n |-> (attribute_drive_en && transfer_start_oe))
        else $error("Attributes not valid while start is asserted.");

    a_busy_oe_release: assert property (@(posedge clk) disable iff (!resetn)
        tenure_done |=> (!address_bus_busy_oe || txn_started))
        else $error("Busy not released after its negated cycle.");

endmodule : address_bus_master_arbitration

// >>> dv/bus_partner_model.sv
// Partner model: the external address arbiter and one other bus master.
module bus_partner_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic grant,
    input wire logic [1:0] address_acknowledge_dly,
    input wire logic retry_req,
    input wire logic other_go,
    input wire logic ts_out_n,
    input wire logic ts_oe,
    input wire logic abb_out_n,
    input wire logic abb_oe,
    output logic bus_grant_in_n,
    output logic address_bus_busy_in_n,
    output logic transfer_start_in_n,
    output logic address_acknowledge_n,
    output logic address_retry_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic f_ts_n, f_abb_n, waiting, rty_arm;
    logic [1:0] cnt;

    // ==========================================================
    // Wires
    // ==========================================================
    // Shared lines have pull-ups, so a released driver reads high, not its last value.
    assign bus_grant_in_n = ~grant;
    assign transfer_start_in_n = (ts_oe ? ts_out_n : 1'b1) & f_ts_n;
    assign address_bus_busy_in_n = (abb_oe ? abb_out_n : 1'b1) & f_abb_n;

    // ==========================================================
    // Acknowledge, retry and the other master
    // ==========================================================
    // Any start on the bus is acknowledged after the chosen delay; retry follows it when retry_req was set at the acknowledge.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            {f_ts_n, f_abb_n, address_acknowledge_n, address_retry_n} <= 4'hF;
            {waiting, rty_arm, cnt} <= 4'h0;
        end
        else
        begin
            address_acknowledge_n <= 1'b1;
            address_retry_n <= 1'b1;
            f_ts_n <= 1'b1;
            if (other_go)
            begin
                f_ts_n <= 1'b0;
                f_abb_n <= 1'b0;
            end
            if (!transfer_start_in_n)
            begin
                waiting <= 1'b1;
                cnt <= address_acknowledge_dly;
            end
            else if (waiting && cnt == 2'h0)
            begin
                address_acknowledge_n <= 1'b0;
                waiting <= 1'b0;
                rty_arm <= retry_req;
            end
            else if (waiting)
            begin
                cnt <= cnt - 2'h1;
            end
            // The other master lets go of busy once its tenure is acknowledged.
            if (!address_acknowledge_n)
            begin
                f_abb_n <= 1'b1;
                address_retry_n <= ~rty_arm;
            end
        end
    end
endmodule : bus_partner_model

// >>> dv/address_bus_master_arbitration_test.sv
// Self-checking bench for the address bus arbitration master.
module address_bus_master_arbitration_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, checkstop, txn_pending, txn_cancel, txn_has_data;
    logic zero_block_pulse, touch_hit_pulse, own_retry_copyback;
    logic grant, retry_req, other_go, hd_q, was_st;
    logic [1:0] address_acknowledge_dly;
    logic bus_grant_in_n, address_bus_busy_in_n, transfer_start_in_n;
    logic address_acknowledge_n, address_retry_n;
    logic bus_request_out_n, bus_request_out_oe, address_bus_busy_out_n, address_bus_busy_oe;
    logic transfer_start_out_n, transfer_start_oe, attribute_drive_en, data_bus_request;
    logic txn_started, tenure_done;
    logic [31:0] seed;
    int n_fail, tests_run, cycles;

    address_bus_master_arbitration dut_u (
        .clk, .resetn, .checkstop, .txn_pending, .txn_cancel, .txn_has_data,
        .zero_block_pulse, .touch_hit_pulse, .own_retry_copyback, .bus_grant_in_n,
        .address_bus_busy_in_n, .transfer_start_in_n, .address_acknowledge_n,
        .address_retry_n, .bus_request_out_n, .bus_request_out_oe, .address_bus_busy_out_n,
        .address_bus_busy_oe, .transfer_start_out_n, .transfer_start_oe,
        .attribute_drive_en, .data_bus_request, .txn_started, .tenure_done);

    bus_partner_model part_u (
        .clk, .resetn, .grant, .address_acknowledge_dly, .retry_req, .other_go,
        .ts_out_n(transfer_start_out_n), .ts_oe(transfer_start_oe),
        .abb_out_n(address_bus_busy_out_n), .abb_oe(address_bus_busy_oe),
        .bus_grant_in_n, .address_bus_busy_in_n, .transfer_start_in_n,
        .address_acknowledge_n, .address_retry_n);

    // ==========================================================
    // Clock, timeout and helpers
    // ==========================================================
    // Bus clock of 40 ns.
    always #20 clk = ~clk;

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic cmp(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic nc(input int n);
        repeat (n) @(negedge clk);
    endtask : nc

    task automatic done_test(input string name);
        $display("test %s finished", name);
    endtask : done_test

    // Waits for the acknowledge, then checks busy negation and release of both pins.
    task automatic finish_tenure();
        int k;
        k = 0;
        while (address_acknowledge_n !== 1'b0 && k < 10)
        begin
            nc(1);
            k++;
        end
        cmp(address_bus_busy_out_n, 1'b0);
        nc(1);
        cmp(address_bus_busy_out_n, 1'b1);
        cmp(address_bus_busy_oe, 1'b1);
        cmp(transfer_start_oe, 1'b0);
        cmp(tenure_done, 1'b1);
        nc(1);
        cmp(address_bus_busy_oe, 1'b0);
    endtask : finish_tenure

    task automatic wrap_up();
        $display("counts: %0d compared, %0d unexpected", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Main sequence
    // ==========================================================
    // Directed corners first, then random traffic from a fixed seed.
    initial
    begin
        {clk, resetn, checkstop, txn_pending, txn_cancel, txn_has_data} = 6'h00;
        {zero_block_pulse, touch_hit_pulse, own_retry_copyback, grant} = 4'h0;
        {retry_req, other_go, hd_q, was_st, address_acknowledge_dly} = 6'h00;
        seed = 32'd95679;
        {n_fail, tests_run, cycles} = '0;
        repeat (16) @(posedge clk);
        cmp(bus_request_out_oe, 1'b0);
        cmp(transfer_start_oe, 1'b0);
        @(posedge clk) resetn <= 1'b1;
        // Parked on an idle bus with the job cancelled: no request, no take.
        @(posedge clk) {grant, txn_pending, txn_cancel} <= 3'h7;
        nc(2);
        cmp(bus_request_out_n, 1'b1);
        cmp(address_bus_busy_oe, 1'b0);
        // Grant drops a cycle before the cancel, so the carried grant has lapsed.
        @(posedge clk) grant <= 1'b0;
        @(posedge clk) txn_cancel <= 1'b0;
        nc(2);
        cmp(bus_request_out_n, 1'b0);
        cmp(transfer_start_oe, 1'b0);
        @(posedge clk) txn_cancel <= 1'b1;
        nc(2);
        cmp(bus_request_out_n, 1'b1);
        @(posedge clk) {txn_pending, txn_cancel} <= 2'h0;
        done_test("cancel");
        // Requested tenures, with and without data.
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            seed = xs(seed);
            {txn_has_data, txn_pending, address_acknowledge_dly} <= {i[0], 1'b1, seed[1:0]};
            nc(2);
            cmp(bus_request_out_n, 1'b0);
            @(posedge clk) grant <= 1'b1;
            nc(2);
            cmp(transfer_start_out_n, 1'b0);
            cmp(attribute_drive_en, 1'b1);
            cmp(address_bus_busy_out_n, 1'b0);
            cmp(data_bus_request, i[0]);
            cmp(bus_request_out_n, 1'b1);
            @(posedge clk) {grant, txn_pending} <= 2'h0;
            nc(1);
            cmp(transfer_start_out_n, 1'b1);
            cmp(transfer_start_oe, 1'b1);
            finish_tenure();
        end
        done_test("tenure");
        // Another master's tenure keeps us off the bus until its acknowledge.
        @(posedge clk) {other_go, address_acknowledge_dly} <= 3'h7;
        @(posedge clk) {other_go, txn_pending, grant} <= 3'h3;
        nc(1);
        while (address_acknowledge_n !== 1'b0 && cycles < 2900)
        begin
            cmp(transfer_start_oe, 1'b0);
            nc(1);
        end
        repeat (4) if (txn_started !== 1'b1) nc(1);
        cmp(txn_started, 1'b1);
        @(posedge clk) {grant, txn_pending} <= 2'h0;
        finish_tenure();
        done_test("foreign");
        // Retry after our acknowledge drops the request unless a copyback needs the bus.
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            {own_retry_copyback, retry_req, address_acknowledge_dly, grant, txn_pending} <= {i[0], 5'h13};
            nc(2);
            cmp(txn_started, 1'b1);
            @(posedge clk) grant <= 1'b0;
            while (address_acknowledge_n !== 1'b0 && cycles < 2900) nc(1);
            nc(2);
            cmp(bus_request_out_n, ~i[0]);
            @(posedge clk) {txn_pending, retry_req, own_retry_copyback} <= 3'h0;
            nc(3);
        end
        done_test("retry");
        // Zero-block and touch-hit pulses each give one cycle of request.
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) {zero_block_pulse, touch_hit_pulse} <= (i == 0) ? 2'h2 : 2'h1;
            @(posedge clk) {zero_block_pulse, touch_hit_pulse} <= 2'h0;
            nc(1);
            cmp(bus_request_out_n, 1'b0);
            nc(1);
            cmp(bus_request_out_n, 1'b1);
        end
        @(posedge clk) checkstop <= 1'b1;
        nc(2);
        cmp(bus_request_out_oe, 1'b0);
        @(posedge clk) checkstop <= 1'b0;
        done_test("pulses");
        // Random grant, pending and cancel; every start is checked as it happens.
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk);
            hd_q = txn_has_data;
            seed = xs(seed);
            {grant, txn_has_data, address_acknowledge_dly} <= seed[3:0];
            txn_pending <= seed[4] | seed[5];
            txn_cancel <= seed[6] & seed[7] & seed[8];
            zero_block_pulse <= seed[9] & seed[10] & seed[11];
            @(negedge clk);
            if (was_st)
                cmp(transfer_start_out_n, 1'b1);
            was_st = (txn_started === 1'b1);
            if (was_st)
            begin
                cmp(data_bus_request, hd_q);
                cmp(bus_request_out_n, 1'b1);
            end
        end
        done_test("random");
        wrap_up();
    end
endmodule : address_bus_master_arbitration_test
